// ===== verilog/slpm_top.sv
// Sleep regulator power mode sequencer, top level
// Functional notes
// - Select bit puts regulator low-power while asleep
// - Select clear keeps normal regulator, fast wake
// - Low-power wake adds settling delay
// - Blocking peripherals force normal regulator mode, except in the unregulated variant
// - Safe wake sources work in low-power sleep
// - Fast oscillator may run for its users
// - Regulator never fully off during sleep
// - Unregulated variant: no select, no delay
`timescale 1ns/1ps
`default_nettype none
module slpm_top
  import slpm_pkg::*;
#(
  parameter bit UNREGULATED = 1'b0,                      // Unregulated variant
  parameter int unsigned SETTLE_CYCLES = SLPM_SETTLE_CYCLES, // Wake settle
  parameter int unsigned N_BLOCK = 4,                    // Blocking peripherals
  parameter int unsigned N_SAFE = 4,                     // Low-power wake sources
  parameter int unsigned N_FOSC = 3                      // Fast oscillator users
) (
  input wire logic CLOCK_I,
  input wire logic RST_I,
  input wire logic [SLPM_ADDR_W-1:0] ADDR_I,
  input wire logic [SLPM_DATA_W-1:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [SLPM_DATA_W-1:0] RDATA_O,
  input wire logic SLEEP_REQ_I,
  input wire logic [N_SAFE-1:0] SAFE_WAKE_I,
  input wire logic OTHER_WAKE_I,
  input wire logic [N_BLOCK-1:0] BLOCK_EN_I,
  input wire logic [N_FOSC-1:0] FOSC_USER_I,
  output logic ASLEEP_O,
  output logic REG_LOWPOWER_O,
  output logic REG_ON_O,
  output logic FOSC_RUN_O,
  output logic WAKE_ACK_O
);
  slpm_ctl_if ctl ();

  slpm_state_t state_reg;    // Sequencer state
  slpm_state_t state_next;   // Next sequencer state
  logic lp_reg;              // Regulator low-power drive
  logic lp_next;             // Next regulator drive
  logic asleep_reg;          // Sleep indication
  logic fosc_reg;            // Fast oscillator run request
  logic ack_reg;             // Wake acknowledge pulse
  logic ack_next;            // Next acknowledge
  logic reg_on_reg;          // Regulator enable
  logic blocked;             // Some blocking peripheral enabled
  logic wake_any;            // Any wake event
  logic lp_allowed;          // Low-power sleep may be used
  logic timer_start;         // Launch settle delay
  logic timer_busy;          // Settle delay running
  logic timer_done;          // Settle delay last cycle
  logic in_sleep;            // State is sleep
  logic in_settle;           // State is settle

  ////////////////////////////////////////////////////////////////////////
  // Register file and settle timer
  slpm_regfile #(
    .UNREGULATED(UNREGULATED)
  ) u_regs (
    .clk_i(CLOCK_I),
    .rst_i(RST_I),
    .addr_i(ADDR_I),
    .wdata_i(WDATA_I),
    .wr_i(WR_I),
    .rd_i(RD_I),
    .rdata_o(RDATA_O),
    .ctl(ctl.regs)
  );

  slpm_settle_timer #(
    .CYCLES(SETTLE_CYCLES)
  ) u_settle (
    .clk_i(CLOCK_I),
    .rst_i(RST_I),
    .start_i(timer_start),
    .busy_o(timer_busy),
    .done_o(timer_done)
  );

  ////////////////////////////////////////////////////////////////////////
  // Decode of events and conditions
  assign blocked = |BLOCK_EN_I;
  // Safe sources are never masked by the regulator mode
  assign wake_any = (|SAFE_WAKE_I) || OTHER_WAKE_I;
  assign lp_allowed = ctl.low_power_sleep_select && !blocked;
  assign in_sleep = (state_reg == SLPM_SLEEP);
  assign in_settle = (state_reg == SLPM_SETTLE);
  // Delay only when the regulator really was in low power, never unregulated
  assign timer_start = in_sleep && wake_any && lp_reg && !UNREGULATED;

  ////////////////////////////////////////////////////////////////////////
  // Next state and outputs
  always_comb begin
    state_next = state_reg;
    ack_next = 1'b0;
    case (state_reg)
      SLPM_AWAKE: begin
        // Enter sleep on the core request
        if (SLEEP_REQ_I) begin
          state_next = SLPM_SLEEP;
        end
      end
      SLPM_SLEEP: begin
        if (wake_any && timer_start) begin
          state_next = SLPM_SETTLE;
        end else if (wake_any) begin
          state_next = SLPM_AWAKE;
          ack_next = 1'b1;
        end
      end
      SLPM_SETTLE: begin
        // Acknowledge only once the count ran out
        if (timer_done) begin
          state_next = SLPM_AWAKE;
          ack_next = 1'b1;
        end
      end
      default: begin
        state_next = SLPM_AWAKE;
      end
    endcase
  end

  // Low-power drive while asleep; the unregulated part always sleeps lowest
  always_comb begin
    if (state_next == SLPM_SLEEP) begin
      lp_next = UNREGULATED ? 1'b1 : lp_allowed;
    end else begin
      lp_next = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // State and output registers
  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      state_reg <= SLPM_AWAKE;
      lp_reg <= 1'b0;
      ack_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      lp_reg <= lp_next;
      ack_reg <= ack_next;
    end
  end

  // Sleep flag, oscillator keep-alive and regulator enable
  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      asleep_reg <= 1'b0;
      fosc_reg <= 1'b1;
      reg_on_reg <= 1'b0;
    end else begin
      asleep_reg <= (state_next == SLPM_SLEEP);
      fosc_reg <= (state_next != SLPM_SLEEP) || (|FOSC_USER_I);
      reg_on_reg <= 1'b1;
    end
  end

  assign ASLEEP_O = asleep_reg;
  assign REG_LOWPOWER_O = lp_reg;
  assign REG_ON_O = reg_on_reg;
  assign FOSC_RUN_O = fosc_reg;
  assign WAKE_ACK_O = ack_reg;
  assign ctl.asleep = asleep_reg;
  assign ctl.settling = timer_busy;
  assign ctl.lp_active = lp_reg;
  assign ctl.forced_normal = in_sleep && blocked && ctl.low_power_sleep_select;

  ////////////////////////////////////////////////////////////////////////
  // Helper: cycles spent in settle
  logic [31:0] settle_seen;
  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      settle_seen <= 32'h0000_0000;
    end else if (in_settle) begin
      settle_seen <= settle_seen + 32'h0000_0001;
    end else begin
      settle_seen <= 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  AST_LP_ENTRY: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    (state_reg == SLPM_AWAKE && SLEEP_REQ_I && ctl.low_power_sleep_select && !blocked)
    |=> REG_LOWPOWER_O && ASLEEP_O)
    else $error("low-power not entered with select set");
  AST_LP_ONLY_ASLEEP: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    REG_LOWPOWER_O |-> ASLEEP_O && in_sleep)
    else $error("low-power drive while awake");
  AST_NORMAL_FAST: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    (in_sleep && wake_any && !REG_LOWPOWER_O) |=> WAKE_ACK_O && !ASLEEP_O)
    else $error("normal sleep wake not immediate");
  AST_SETTLE_DELAY: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    (in_sleep && wake_any && REG_LOWPOWER_O && !UNREGULATED)
    |=> !WAKE_ACK_O ##1 ctl.settling)
    else $error("low-power wake without settling");
  AST_ACK_COUNT: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    (in_settle && state_next == SLPM_AWAKE) |-> settle_seen == SETTLE_CYCLES - 1)
    else $error("wake acknowledged before settle count");
  AST_FORCE_NORMAL: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    (state_next == SLPM_SLEEP && blocked && !UNREGULATED) |=> !REG_LOWPOWER_O)
    else $error("blocking peripheral did not force normal mode");
  AST_SAFE_WAKE: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    (in_sleep && |SAFE_WAKE_I) |=> !in_sleep)
    else $error("safe wake source ignored");
  AST_FOSC_KEEP: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    (|FOSC_USER_I) |=> FOSC_RUN_O)
    else $error("fast oscillator stopped while in use");
  AST_REG_ON: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    !$past(RST_I) |-> REG_ON_O)
    else $error("regulator switched off");
  AST_UNREG: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    (UNREGULATED && in_sleep && wake_any) |=> WAKE_ACK_O && !REG_LOWPOWER_O)
    else $error("unregulated wake delayed");

  ////////////////////////////////////////////////////////////////////////
  // Sequencing checks
  // Wake acknowledge is a single-cycle pulse
  AST_ACK_PULSE: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    WAKE_ACK_O
    |=> !WAKE_ACK_O)
    else $error("wake acknowledge longer than one cycle");

  // Acknowledge only once sleep and low power are left
  AST_ACK_AWAKE: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    WAKE_ACK_O
    |-> !ASLEEP_O && !REG_LOWPOWER_O)
    else $error("wake acknowledged while still asleep");

  // Settling runs with the regulator back in normal mode
  AST_SETTLE_VIEW: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    in_settle
    |-> !ASLEEP_O && !REG_LOWPOWER_O && REG_ON_O)
    else $error("regulator not normal while settling");

  // Settling is left only when the count runs out
  AST_SETTLE_HOLD: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    (in_settle && !timer_done)
    |=> in_settle)
    else $error("settling left before count expired");

  // The counter is running for the whole settle phase
  AST_SETTLE_TIMER: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    in_settle
    |-> ctl.settling)
    else $error("settle phase without running counter");

  // The unregulated part never settles
  AST_UNREG_NO_SETTLE: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    UNREGULATED
    |-> !in_settle)
    else $error("unregulated variant entered settling");

  // The unregulated part always sleeps in its lowest state
  AST_UNREG_LP_SLEEP: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    (UNREGULATED && in_sleep)
    |-> REG_LOWPOWER_O)
    else $error("unregulated variant not lowest while asleep");

  // Normal-mode sleep never goes through settling
  AST_NORMAL_NO_SETTLE: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    (in_sleep && !REG_LOWPOWER_O)
    |=> !in_settle)
    else $error("normal sleep wake went through settling");

  // Select clear keeps the regulator normal
  AST_SELECT_CLEAR: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    (!UNREGULATED && !ctl.low_power_sleep_select)
    |=> !REG_LOWPOWER_O)
    else $error("low-power drive with select clear");

  // Fast oscillator always runs while awake
  AST_FOSC_AWAKE: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    !ASLEEP_O
    |-> FOSC_RUN_O)
    else $error("fast oscillator stopped while awake");

  // Fast oscillator stops in sleep without users
  AST_FOSC_IDLE_STOP: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    (state_next == SLPM_SLEEP && !(|FOSC_USER_I))
    |=> !FOSC_RUN_O)
    else $error("fast oscillator kept without users");

  // Core request while awake enters sleep
  AST_SLEEP_ENTRY: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    (state_reg == SLPM_AWAKE && SLEEP_REQ_I)
    |=> ASLEEP_O)
    else $error("sleep request not taken");

  // Low power resumes once blocking peripherals are gone
  AST_LP_RELEASE: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    (in_sleep && !wake_any && !blocked && ctl.low_power_sleep_select)
    |=> REG_LOWPOWER_O)
    else $error("low power not resumed after release");

endmodule : slpm_top
`default_nettype wire

// ===== verilog/slpm_pkg.sv
// Constants shared by the sleep regulator power mode block
`default_nettype none
package slpm_pkg;
  // Register bus geometry
  localparam int unsigned SLPM_ADDR_W = 4;
  localparam int unsigned SLPM_DATA_W = 8;
  // Register offsets
  localparam logic [3:0] SLPM_OFS_CTRL = 4'h0;
  localparam logic [3:0] SLPM_OFS_STAT = 4'h1;
  // Field positions in the control register
  localparam int unsigned SLPM_CTRL_LPSEL_BIT = 1;
  // Field positions in the status register
  localparam int unsigned SLPM_STAT_ASLEEP_BIT = 0;
  localparam int unsigned SLPM_STAT_SETTLE_BIT = 1;
  localparam int unsigned SLPM_STAT_LPACT_BIT = 2;
  localparam int unsigned SLPM_STAT_FORCED_BIT = 3;
  // Reset values
  localparam logic SLPM_LPSEL_RST = 1'b0;
  localparam logic [7:0] SLPM_DATA_ZERO = 8'h00;
  // Clock and wake settling timing
  localparam int unsigned SLPM_CLK_PERIOD_NS = 100;
  localparam int unsigned SLPM_SETTLE_TIME_NS = 5000;
  // Least time rounds up, never below one cycle
  localparam int unsigned SLPM_SETTLE_CYC_RAW =
    (SLPM_SETTLE_TIME_NS + SLPM_CLK_PERIOD_NS - 1) / SLPM_CLK_PERIOD_NS;
  localparam int unsigned SLPM_SETTLE_CYCLES =
    (SLPM_SETTLE_CYC_RAW < 1) ? 1 : SLPM_SETTLE_CYC_RAW;
  // Power sequencer states
  typedef enum logic [1:0] {
    SLPM_AWAKE,
    SLPM_SLEEP,
    SLPM_SETTLE
  } slpm_state_t;
endpackage : slpm_pkg
`default_nettype wire

// ===== verilog/slpm_ctl_if.sv
// Control and status carrier between register file and sequencer
`timescale 1ns/1ps
`default_nettype none
interface slpm_ctl_if;
  logic low_power_sleep_select; // Software low-power sleep choice
  logic asleep;                 // Sequencer is in sleep
  logic settling;               // Wake settling delay running
  logic lp_active;              // Regulator in low-power state
  logic forced_normal;          // Blocking peripheral overrides choice
  modport regs (output low_power_sleep_select, input asleep, input settling,
    input lp_active, input forced_normal);
  modport seq (input low_power_sleep_select, output asleep, output settling,
    output lp_active, output forced_normal);
endinterface : slpm_ctl_if
`default_nettype wire

// ===== verilog/slpm_regfile.sv
// Register bus slave holding the regulator control register
`timescale 1ns/1ps
`default_nettype none
module slpm_regfile
  import slpm_pkg::*;
#(
  parameter bit UNREGULATED = 1'b0
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [SLPM_ADDR_W-1:0] addr_i,
  input wire logic [SLPM_DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [SLPM_DATA_W-1:0] rdata_o,
  slpm_ctl_if.regs ctl
);
  logic lpsel_reg;                    // Stored selection bit
  logic [SLPM_DATA_W-1:0] rdata_reg;  // Read data register
  logic [SLPM_DATA_W-1:0] ctrl_view;  // Control register image
  logic [SLPM_DATA_W-1:0] stat_view;  // Status register image
  logic [SLPM_DATA_W-1:0] rd_mux;     // Selected read value
  logic wr_ctrl;                      // Write hits control register

  ////////////////////////////////////////////////////////////////////////
  // Decode and read selection
  assign wr_ctrl = wr_i && (addr_i == SLPM_OFS_CTRL) && !UNREGULATED;
  always_comb begin
    ctrl_view = SLPM_DATA_ZERO;
    ctrl_view[SLPM_CTRL_LPSEL_BIT] = lpsel_reg;
    stat_view = SLPM_DATA_ZERO;
    stat_view[SLPM_STAT_ASLEEP_BIT] = ctl.asleep;
    stat_view[SLPM_STAT_SETTLE_BIT] = ctl.settling;
    stat_view[SLPM_STAT_LPACT_BIT] = ctl.lp_active;
    stat_view[SLPM_STAT_FORCED_BIT] = ctl.forced_normal;
  end
  // Unmapped offsets read as zero
  assign rd_mux = (addr_i == SLPM_OFS_CTRL) ? ctrl_view :
                  (addr_i == SLPM_OFS_STAT) ? stat_view : SLPM_DATA_ZERO;

  ////////////////////////////////////////////////////////////////////////
  // Selection bit; absent in the unregulated variant
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      lpsel_reg <= SLPM_LPSEL_RST;
    end else if (wr_ctrl) begin
      lpsel_reg <= wdata_i[SLPM_CTRL_LPSEL_BIT];
    end
  end

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_reg <= SLPM_DATA_ZERO;
    end else begin
      rdata_reg <= rd_i ? rd_mux : SLPM_DATA_ZERO;
    end
  end

  assign rdata_o = rdata_reg;
  assign ctl.low_power_sleep_select = lpsel_reg;
endmodule : slpm_regfile
`default_nettype wire

// ===== verilog/slpm_settle_timer.sv
// Wake settling delay counter
`timescale 1ns/1ps
`default_nettype none
module slpm_settle_timer #(
  parameter int unsigned CYCLES = 50
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic start_i,
  output logic busy_o,
  output logic done_o
);
  localparam int unsigned CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] CNT_LOAD = CW'(CYCLES);
  localparam logic [CW-1:0] CNT_ONE = CW'(1);
  localparam logic [CW-1:0] CNT_ZERO = CW'(0);
  logic [CW-1:0] cnt_reg; // Cycles left
  logic last;             // Final counting cycle

  assign last = (cnt_reg == CNT_ONE);

  ////////////////////////////////////////////////////////////////////////
  // Load on start, count down to zero
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_reg <= CNT_ZERO;
    end else if (start_i) begin
      cnt_reg <= CNT_LOAD;
    end else if (cnt_reg != CNT_ZERO) begin
      cnt_reg <= cnt_reg - CNT_ONE;
    end
  end

  assign busy_o = (cnt_reg != CNT_ZERO);
  assign done_o = last;
endmodule : slpm_settle_timer
`default_nettype wire

// ===== tb/slpm_core_model.sv
// Core sleep-control model: sleep entry pulses, wake events, wake latency
`timescale 1ns/1ps
`default_nettype none
module slpm_core_model #(
  parameter int unsigned N_SAFE = 4 // Low-power wake sources
) (
  input wire logic clk_i,
  input wire logic ack_i,
  output logic sleep_req_o,
  output logic [N_SAFE-1:0] safe_wake_o,
  output logic other_wake_o
);
  ////////////////////////////////////////////////////////////////////////////
  // Idle levels from time zero
  initial begin
    sleep_req_o = 1'b0;
    safe_wake_o = '0;
    other_wake_o = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////
  // One-cycle sleep entry pulse, taken at the second edge
  task automatic go_sleep();
    @(posedge clk_i);
    sleep_req_o <= 1'b1;
    @(posedge clk_i);
    sleep_req_o <= 1'b0;
    #1;
  endtask : go_sleep
  // Wake pulse from one source, then count edges until execution may resume
  task automatic wake(input int src, output int lag);
    int n;
    n = 0;
    @(posedge clk_i);
    if (src < N_SAFE) begin
      safe_wake_o[src] <= 1'b1;
    end else begin
      other_wake_o <= 1'b1;
    end
    @(posedge clk_i);
    safe_wake_o <= '0;
    other_wake_o <= 1'b0;
    #1;
    // Bounded wait so a lost acknowledge cannot hang the core
    while (ack_i !== 1'b1 && n < 40) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    lag = n;
  endtask : wake
endmodule : slpm_core_model
`default_nettype wire

// ===== tb/slpm_top_tb.sv
// Self-checking bench for the sleep regulator power mode block
`timescale 1ns/1ps
`default_nettype none
module slpm_top_tb;
  import slpm_pkg::*;
  localparam int unsigned SC = 3; // Short wake settle count
  logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0;
  logic [3:0] addr = 4'h0, block = 4'h0;
  logic [7:0] wdata = 8'h00, rdat, rdat_u;
  logic [2:0] fosc = 3'h0;
  logic sreq, owake, slp, lp, on, frun, ack, slp_u, lp_u, ack_u;
  logic [3:0] swake;
  int fails = 0, samples_checked = 0, lag, i;
  wire logic [7:0] rdo, rdo_u;
  always #50 clk = ~clk; // 10 MHz core clock
  ////////////////////////////////////////////////////////////////////////////
  // Regulated device under test and unregulated variant on shared stimulus
  slpm_top #(.SETTLE_CYCLES(SC)) u_dut (.CLOCK_I(clk), .RST_I(rst), .ADDR_I(addr),
    .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdo), .SLEEP_REQ_I(sreq),
    .SAFE_WAKE_I(swake), .OTHER_WAKE_I(owake), .BLOCK_EN_I(block), .FOSC_USER_I(fosc),
    .ASLEEP_O(slp), .REG_LOWPOWER_O(lp), .REG_ON_O(on), .FOSC_RUN_O(frun), .WAKE_ACK_O(ack));
  slpm_top #(.UNREGULATED(1'b1), .SETTLE_CYCLES(SC)) u_dut_unreg (.CLOCK_I(clk),
    .RST_I(rst), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdo_u),
    .SLEEP_REQ_I(sreq), .SAFE_WAKE_I(swake), .OTHER_WAKE_I(owake), .BLOCK_EN_I(block),
    .FOSC_USER_I(fosc), .ASLEEP_O(slp_u), .REG_LOWPOWER_O(lp_u), .REG_ON_O(),
    .FOSC_RUN_O(), .WAKE_ACK_O(ack_u));
  // Core model acknowledges on the regulated device
  slpm_core_model #(.N_SAFE(4)) u_core (.clk_i(clk), .ack_i(ack), .sleep_req_o(sreq),
    .safe_wake_o(swake), .other_wake_o(owake));
  ////////////////////////////////////////////////////////////////////////////
  // Compare one value, count and report
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // Register write: one cycle strobe
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  // Register read: data stand in the cycle after the strobe
  task automatic rd_reg(input logic [3:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    rdat = rdo;
    rdat_u = rdo_u;
  endtask : rd_reg
  // Verdict and end of run
  task automatic end_of_test();
    $display("Checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_of_test
  ////////////////////////////////////////////////////////////////////////////
  // Watchdog: the whole sequence needs well under 2000 cycles
  initial begin
    #(5000 * 100);
    fails++;
    end_of_test();
  end
  ////////////////////////////////////////////////////////////////////////////
  // Test sequence
  initial begin
    repeat (3) @(posedge clk);
    #1;
    check("reg_on_in_reset", {7'h00, on}, 8'h00);
    check("fosc_in_reset", {7'h00, frun}, 8'h01);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    check("reg_on_after_reset", {7'h00, on}, 8'h01);
    rd_reg(SLPM_OFS_CTRL);
    check("ctrl_reset", rdat, 8'h00);
    rd_reg(4'h7);
    check("unmapped_read", rdat, 8'h00);
    $display("Test reset done");
    // Normal sleep: no low-power, no added delay
    u_core.go_sleep();
    check("normal_asleep", {slp, lp, on}, 8'h05);
    u_core.wake(4, lag);
    check("normal_lag", lag[7:0], 8'h00);
    $display("Test normal sleep done");
    // Low-power sleep woken by each safe source, back to back
    wr_reg(SLPM_OFS_CTRL, 8'h02);
    rd_reg(SLPM_OFS_CTRL);
    check("ctrl_select", rdat, 8'h02);
    check("unreg_ctrl_ignored", rdat_u, 8'h00);
    for (i = 0; i < 4; i++) begin
      u_core.go_sleep();
      check("lp_asleep", {slp, lp, on}, 8'h07);
      if (i == 0) begin
        rd_reg(SLPM_OFS_STAT);
        check("lp_status", rdat, 8'h05);
      end
      u_core.wake(i, lag);
      check("lp_lag", lag[7:0], SC[7:0]);
      check("lp_awake", {slp, lp}, 8'h00);
      @(posedge clk);
      #1;
      check("ack_pulse", {7'h00, ack}, 8'h00);
    end
    $display("Test low-power sleep done");
    // Each blocking peripheral forces normal mode; unregulated ignores it
    for (i = 0; i < 4; i++) begin
      block <= 4'h1 << i;
      u_core.go_sleep();
      check("forced_normal", {slp, lp}, 8'h02);
      check("unreg_lowpower", {slp_u, lp_u}, 8'h03);
      if (i == 3) begin
        rd_reg(SLPM_OFS_STAT);
        check("forced_status", rdat, 8'h09);
        block <= 4'h0;
        @(posedge clk);
        @(posedge clk);
        #1;
        check("release_lowpower", {7'h00, lp}, 8'h01);
        u_core.wake(4, lag);
        check("release_lag", lag[7:0], SC[7:0]);
      end else begin
        u_core.wake(4, lag);
        check("forced_lag", lag[7:0], 8'h00);
        check("unreg_ack", {7'h00, ack_u}, 8'h01);
        check("unreg_awake", {slp_u, lp_u}, 8'h00);
      end
    end
    $display("Test blocking peripherals done");
    // Fast oscillator kept only for its users during sleep
    check("fosc_awake", {7'h00, frun}, 8'h01);
    u_core.go_sleep();
    check("fosc_idle_sleep", {7'h00, frun}, 8'h00);
    for (i = 0; i < 3; i++) begin
      @(posedge clk);
      fosc <= 3'h1 << i;
      @(posedge clk);
      @(posedge clk);
      #1;
      check("fosc_user", {7'h00, frun}, 8'h01);
    end
    fosc <= 3'h0;
    u_core.wake(1, lag);
    check("fosc_wake_on", {7'h00, frun}, 8'h01);
    $display("Test fast oscillator done");
    end_of_test();
  end
endmodule : slpm_top_tb
`default_nettype wire
